// File: include/dbw_pkg.sv
// Package for the burst SRAM core: organisation constants, beat records, state enums.
// Assumes a single core clock; the two data beats of a burst arrive on consecutive cycles.
package dbw_pkg;
   // Lane geometry
   localparam int LANE_W = 9;
   localparam int MAX_LANES = 4;
   localparam int DATA_W = LANE_W * MAX_LANES;
   localparam int ADDR_W = 8;
   localparam int BURST_LEN = 2;
   localparam logic [0:0] OFS_FIRST = 1'h0;
   localparam logic [0:0] OFS_SECOND = 1'h1;
   localparam logic [DATA_W-1:0] RDATA_RST = 36'h0;
   localparam logic [MAX_LANES-1:0] MASK_NONE = 4'hf;

   // Organisation codes: 36, 18 or 9 bits wide
   typedef enum logic [1:0] {DBW_ORG_X36, DBW_ORG_X18, DBW_ORG_X9} dbw_org_t;

   // Burst sequencer states
   typedef enum logic [1:0] {DBW_IDLE, DBW_BEAT0, DBW_BEAT1} dbw_state_t;

   // One command sampled on the true clock rise
   typedef struct packed {
      logic rd_sel_n;
      logic wr_sel_n;
      logic [ADDR_W-1:0] rd_addr;
      logic [ADDR_W-1:0] wr_addr;
   } dbw_cmd_t;

   // One write data beat with its lane masks
   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [MAX_LANES-1:0] mask_n;
   } dbw_beat_t;
endpackage

// File: hdl/dbw_lane_merge.sv
// Merges one write beat into the stored word lane by lane.
// Assumes the mask has already been qualified by the organisation.
`timescale 1ns/100ps
module dbw_lane_merge #(
   parameter int LANES = 4,
   parameter int LW = 9
)(
   // Stored word and new beat
   input wire logic [LANES*LW-1:0] old_i,
   input wire logic [LANES*LW-1:0] new_i,
   input wire logic [LANES-1:0] mask_n_i,
   // Merged result
   output logic [LANES*LW-1:0] merged_o
);
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         // Masked lanes keep their previous contents
         assign merged_o[g*LW +: LW] = mask_n_i[g] ? old_i[g*LW +: LW] : new_i[g*LW +: LW];
      end
   endgenerate
endmodule

// File: hdl/dbw_sram_core.sv
// Burst SRAM core: byte-masked two-beat writes, two-beat reads, write-to-read forwarding.
// Assumes the true/inverted input clock rises are presented as one core clock with a
// beat phase: the true-edge beat in the command cycle, the inverted-edge beat the next.
//
// Overview of operation
// RL1: x36: masks 0..3 low write lanes 0..3 of nine bits each; high skips.
// RL2: x18: mask 0 low writes bits 0-8, mask 1 bits 9-17.
// RL3: x9: single mask low writes bits 0-8, high writes nothing.
// RL4: Masks sampled separately with each beat; may change between beats.
// RL5: Masks affect the array only during an accepted write burst.
// RL6: Burst address is external address plus one internal low bit.
// RL7: Internal bit runs fixed order, first beat zero then one.
// RL8: Each read or write burst ends after two beats.
// RL9: Read and write sequencers are separate and run concurrently.
// RL10: Both sequencers advance on the true input clock rise.
// RL11: True-edge data goes to offset zero, inverted-edge data to one.
// RL12: Low write select starts write, low read select starts read; both high idle.
// RL13: Read beats follow output clocks, or input clocks when output clocks held high.
// RL14: Read of an address being written returns the new data.
// RL15: Masked lanes keep stored contents while unmasked lanes update.
`timescale 1ns/100ps
module dbw_sram_core #(
   parameter int ADDR_W = dbw_pkg::ADDR_W,
   parameter dbw_pkg::dbw_org_t ORG = dbw_pkg::DBW_ORG_X36
)(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Command pins
   input wire logic rd_sel_n_i,
   input wire logic wr_sel_n_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   input wire logic [ADDR_W-1:0] wr_addr_i,
   // Write data and lane masks, one beat per cycle
   input wire logic [dbw_pkg::DATA_W-1:0] wdata_i,
   input wire logic byte_write_lane0_n_i,
   input wire logic byte_write_lane1_n_i,
   input wire logic byte_write_lane2_n_i,
   input wire logic byte_write_lane3_n_i,
   input wire logic single_lane_write_mask_n_i,
   // Output clock hold: high when both output clocks are tied high
   input wire logic out_clk_held_i,
   // Read data
   output logic [dbw_pkg::DATA_W-1:0] rdata_o,
   output logic rvalid_o,
   output logic rbeat_o,
   output logic out_clk_sel_o
);
   localparam int DW = dbw_pkg::DATA_W;
   localparam int ML = dbw_pkg::MAX_LANES;
   // One word per beat: the internal burst bit doubles the depth
   localparam int DEPTH = 2 ** (ADDR_W + 1);

   // Two-flop input synchronisers; all pin inputs pass these first
   localparam int SYW = 2 + 2 * ADDR_W + DW + 5 + 1;
   // Idle levels after reset: selects and masks high, held input low, so no output flickers
   localparam logic [SYW-1:0] SYNC_RST = {{(SYW - 1){1'b1}}, 1'b0};
   logic [SYW-1:0] pins_raw;
   logic [SYW-1:0] sync1_q;
   logic [SYW-1:0] sync2_q;
   assign pins_raw = {rd_sel_n_i, wr_sel_n_i, rd_addr_i, wr_addr_i, wdata_i,
                      byte_write_lane3_n_i, byte_write_lane2_n_i, byte_write_lane1_n_i,
                      byte_write_lane0_n_i, single_lane_write_mask_n_i, out_clk_held_i};

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
      end
      else
      begin
         sync1_q <= pins_raw;
         sync2_q <= sync1_q;
      end
   end

   logic s_rd_n;
   logic s_wr_n;
   logic [ADDR_W-1:0] s_rd_addr;
   logic [ADDR_W-1:0] s_wr_addr;
   logic [DW-1:0] s_wdata;
   logic [ML-1:0] s_lane_n;
   logic s_single_n;
   logic s_held;
   assign {s_rd_n, s_wr_n, s_rd_addr, s_wr_addr, s_wdata, s_lane_n, s_single_n, s_held} = sync2_q;

   // Reduce the pin masks to the lanes that exist in this organisation
   function automatic logic [ML-1:0] org_mask(input logic [ML-1:0] lanes_n, input logic single_n);
      logic [ML-1:0] m;
      m = dbw_pkg::MASK_NONE;
      unique case (ORG)
         dbw_pkg::DBW_ORG_X36: m = lanes_n;                       // [RL1]
         dbw_pkg::DBW_ORG_X18: m = {2'h3, lanes_n[1:0]};          // [RL2]
         dbw_pkg::DBW_ORG_X9:  m = {3'h7, single_n};              // [RL3]
         default: m = dbw_pkg::MASK_NONE;
      endcase
      return m;
   endfunction

   // Second cycle of a burst; both sequencers decode it several times
   function automatic logic in_second_beat(input dbw_pkg::dbw_state_t st);
      return st == dbw_pkg::DBW_BEAT0;
   endfunction

   // Array, addressed by {external address, burst bit}
   logic [DW-1:0] mem_q [DEPTH];

   // Write sequencer
   dbw_pkg::dbw_state_t wr_state_q;
   dbw_pkg::dbw_state_t wr_state_d;
   logic [ADDR_W-1:0] wr_addr_q;
   logic wr_ofs;
   logic wr_active;
   logic [ML-1:0] beat_mask_n;
   logic [ADDR_W:0] wr_waddr;
   logic [DW-1:0] merged;

   // A write is accepted on a low select; its first beat is this cycle
   always_comb
   begin
      wr_state_d = dbw_pkg::DBW_IDLE;
      unique case (wr_state_q)
         dbw_pkg::DBW_IDLE: wr_state_d = !s_wr_n ? dbw_pkg::DBW_BEAT0 : dbw_pkg::DBW_IDLE; // [RL12]
         // A new write may follow a finished burst with no idle cycle between
         dbw_pkg::DBW_BEAT1: wr_state_d = !s_wr_n ? dbw_pkg::DBW_BEAT0 : dbw_pkg::DBW_IDLE; // [RL12]
         // A select seen here is dropped: the burst ends after its second beat
         dbw_pkg::DBW_BEAT0: wr_state_d = dbw_pkg::DBW_BEAT1; // [RL8]
         default: wr_state_d = dbw_pkg::DBW_IDLE;
      endcase
   end

   // Second beat always pairs with the command of the previous cycle
   assign wr_active = in_second_beat(wr_state_q) || !s_wr_n;
   assign wr_ofs = in_second_beat(wr_state_q) ? dbw_pkg::OFS_SECOND : dbw_pkg::OFS_FIRST; // [RL7] [RL11]
   assign wr_waddr = in_second_beat(wr_state_q) ? {wr_addr_q, wr_ofs} : {s_wr_addr, wr_ofs}; // [RL6]

   // Masks taken fresh for every beat; outside a burst they are forced to write nothing
   always_comb
   begin
      beat_mask_n = dbw_pkg::MASK_NONE; // [RL5]
      if (wr_active)
      begin
         beat_mask_n = org_mask(s_lane_n, s_single_n); // [RL4]
      end
   end

   // Both sequencers step on the true clock rise only
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         wr_state_q <= dbw_pkg::DBW_IDLE;
      end
      else
      begin
         wr_state_q <= wr_state_d; // [RL10]
      end
   end

   // Address kept for the second beat, since the pins may already carry the next command
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         wr_addr_q <= '0;
      end
      else if (!in_second_beat(wr_state_q))
      begin
         wr_addr_q <= s_wr_addr;
      end
   end

   dbw_lane_merge #(
      .LANES(ML),
      .LW(dbw_pkg::LANE_W)
   ) u_merge (
      .old_i(mem_q[wr_waddr]),
      .new_i(s_wdata),
      .mask_n_i(beat_mask_n),
      .merged_o(merged)
   );

   // Array is not reset; contents are undefined until written
   always_ff @(posedge mclk_i)
   begin
      if (resetn_i && wr_active)
      begin
         mem_q[wr_waddr] <= merged; // [RL15]
      end
   end

   // Read sequencer, independent of the write one
   dbw_pkg::dbw_state_t rd_state_q;
   dbw_pkg::dbw_state_t rd_state_d;
   logic [ADDR_W-1:0] rd_addr_q;
   logic [ADDR_W:0] rd_raddr;
   logic rd_ofs;
   logic rd_active;
   logic [DW-1:0] rd_word;

   always_comb
   begin
      rd_state_d = dbw_pkg::DBW_IDLE;
      unique case (rd_state_q)
         dbw_pkg::DBW_IDLE: rd_state_d = !s_rd_n ? dbw_pkg::DBW_BEAT0 : dbw_pkg::DBW_IDLE; // [RL12] [RL9]
         dbw_pkg::DBW_BEAT1: rd_state_d = !s_rd_n ? dbw_pkg::DBW_BEAT0 : dbw_pkg::DBW_IDLE; // [RL12]
         // Reads stop after two beats whatever the select does meanwhile
         dbw_pkg::DBW_BEAT0: rd_state_d = dbw_pkg::DBW_BEAT1; // [RL8]
         default: rd_state_d = dbw_pkg::DBW_IDLE;
      endcase
   end

   assign rd_active = in_second_beat(rd_state_q) || !s_rd_n;
   assign rd_ofs = in_second_beat(rd_state_q) ? dbw_pkg::OFS_SECOND : dbw_pkg::OFS_FIRST; // [RL7]
   assign rd_raddr = in_second_beat(rd_state_q) ? {rd_addr_q, rd_ofs} : {s_rd_addr, rd_ofs}; // [RL6]

   // A beat being written this cycle is forwarded with its own masking applied, so a read
   // never returns the stale word of a write still in flight
   always_comb
   begin
      rd_word = mem_q[rd_raddr];
      if (wr_active && (wr_waddr == rd_raddr))
      begin
         rd_word = merged; // [RL14]
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rd_state_q <= dbw_pkg::DBW_IDLE;
      end
      else
      begin
         rd_state_q <= rd_state_d; // [RL10]
      end
   end

   // Read address kept for the second beat
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rd_addr_q <= '0;
      end
      else if (!in_second_beat(rd_state_q))
      begin
         rd_addr_q <= s_rd_addr;
      end
   end

   // Read data registered; it stands until the next read beat replaces it
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rdata_o <= dbw_pkg::RDATA_RST;
      end
      else if (rd_active)
      begin
         rdata_o <= rd_word;
      end
   end

   // One valid pulse per read beat
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rvalid_o <= 1'b0;
      end
      else
      begin
         rvalid_o <= rd_active; // [RL8]
      end
   end

   // Burst offset of the read beat flagged by rvalid_o; low whenever rvalid_o is low
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         rbeat_o <= 1'b0;
      end
      else
      begin
         rbeat_o <= rd_ofs; // [RL7]
      end
   end

   // Output reference: 1 selects input clocks because output clocks are held high
   always_ff @(posedge mclk_i)
   begin
      if (!resetn_i)
      begin
         out_clk_sel_o <= 1'b0;
      end
      else
      begin
         out_clk_sel_o <= s_held; // [RL13]
      end
   end
endmodule

// File: dv/dbw_sram_core_props.sv
// Checker for the burst core's read sequencing and reference clock choice.
// Sees only the core's ports; bound to every core instance below.
`timescale 1ns/100ps
module dbw_sram_core_props (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Watched signals
   input wire logic rd_sel_n_i,
   input wire logic wr_sel_n_i,
   input wire logic out_clk_held_i,
   input wire logic rvalid_o,
   input wire logic rbeat_o,
   input wire logic out_clk_sel_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);
   sequence s_beat0;
      rvalid_o && !rbeat_o;
   endsequence
   sequence s_beat1;
      rvalid_o && rbeat_o;
   endsequence
   chk_read_two_beats: assert property ($fell(rd_sel_n_i) |-> ##3 s_beat0 ##1 s_beat1)
      else $error("read burst beats missing");
   chk_beat_order: assert property (s_beat1 |-> $past(rvalid_o && !rbeat_o))
      else $error("second beat without first");
   chk_burst_ends: assert property (s_beat1 |=> !(rvalid_o && rbeat_o))
      else $error("extra beat after burst");
   chk_read_cause: assert property (s_beat0 |-> !$past(rd_sel_n_i, 3))
      else $error("read beat without read select");
   chk_nop_quiet: assert property ($past(rd_sel_n_i, 3) && $past(rd_sel_n_i, 4) |-> !rvalid_o)
      else $error("read data during no-operation");
   chk_rw_concurrent: assert property ($fell(rd_sel_n_i) && $fell(wr_sel_n_i) |-> ##3 s_beat0 ##1 s_beat1)
      else $error("read lost beside write");
   chk_clk_held: assert property (out_clk_held_i [*5] |-> out_clk_sel_o)
      else $error("input clock reference not chosen");
   chk_clk_output: assert property (!out_clk_held_i [*5] |-> !out_clk_sel_o)
      else $error("output clock reference not chosen");
endmodule
bind dbw_sram_core dbw_sram_core_props u_props (.mclk_i, .resetn_i, .rd_sel_n_i, .wr_sel_n_i,
   .out_clk_held_i, .rvalid_o, .rbeat_o, .out_clk_sel_o);

// File: dv/dbw_ctl_model.sv
// Memory controller model driving the core's command and write beat pins.
// Drives at falling edges; released pins show inverted values so stale data never passes.
`timescale 1ns/100ps
module dbw_ctl_model (
   // Clock and read data
   input wire logic mclk_i,
   input wire logic [dbw_pkg::DATA_W-1:0] rdata_i,
   // Command and beat pins
   output logic rd_sel_n_o = 1'h1,
   output logic wr_sel_n_o = 1'h1,
   output logic [dbw_pkg::ADDR_W-1:0] rd_addr_o = 8'h0,
   output logic [dbw_pkg::ADDR_W-1:0] wr_addr_o = 8'h0,
   output dbw_pkg::dbw_beat_t beat_o = 40'hf00000000f
);
   logic [dbw_pkg::DATA_W-1:0] q0;
   logic [dbw_pkg::DATA_W-1:0] q1;
   task automatic cmd(input logic rd, input logic wr, input logic [7:0] ra, input logic [7:0] wa,
      input dbw_pkg::dbw_beat_t b0, input dbw_pkg::dbw_beat_t b1);
      @(negedge mclk_i);
      rd_sel_n_o = !rd;
      wr_sel_n_o = !wr;
      rd_addr_o = ra;
      wr_addr_o = wa;
      beat_o = b0;
      @(negedge mclk_i);
      rd_sel_n_o = 1'h1;
      wr_sel_n_o = 1'h1;
      beat_o = b1;
      @(negedge mclk_i);
      rd_addr_o = ~rd_addr_o;
      wr_addr_o = ~wr_addr_o;
      beat_o = ~beat_o;
      if (rd)
      begin
         // First read beat stands from the third rise after the select is driven
         @(negedge mclk_i);
         q0 = rdata_i;
         @(negedge mclk_i);
         q1 = rdata_i;
      end
   endtask
endmodule

// File: dv/ddr_sram_byte_write_burst_test.sv
// Self-checking bench for the burst core in the 36-, 18- and 9-bit organisations.
// Bursts come from the controller model; read words are compared with hand-worked values.
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, g); end end
module ddr_sram_byte_write_burst_test;
   logic mclk = 1'h0;
   logic resetn = 1'h0;
   logic held = 1'h0;
   logic rd_sel_n;
   logic wr_sel_n;
   logic [dbw_pkg::ADDR_W-1:0] rd_addr;
   logic [dbw_pkg::ADDR_W-1:0] wr_addr;
   dbw_pkg::dbw_beat_t beat;
   logic [dbw_pkg::DATA_W-1:0] rdata;
   logic [dbw_pkg::DATA_W-1:0] rdata18;
   logic [dbw_pkg::DATA_W-1:0] rdata9;
   logic rvalid;
   logic rbeat;
   logic clk_sel;
   int failures = 0;
   int tests_run = 0;
   always #50 mclk = !mclk;
   dbw_ctl_model u_ctl (.mclk_i(mclk), .rdata_i(rdata), .rd_sel_n_o(rd_sel_n), .wr_sel_n_o(wr_sel_n),
      .rd_addr_o(rd_addr), .wr_addr_o(wr_addr), .beat_o(beat));
   dbw_sram_core u_dut (.mclk_i(mclk), .resetn_i(resetn), .rd_sel_n_i(rd_sel_n), .wr_sel_n_i(wr_sel_n),
      .rd_addr_i(rd_addr), .wr_addr_i(wr_addr), .wdata_i(beat.data), .byte_write_lane0_n_i(beat.mask_n[0]),
      .byte_write_lane1_n_i(beat.mask_n[1]), .byte_write_lane2_n_i(beat.mask_n[2]),
      .byte_write_lane3_n_i(beat.mask_n[3]), .single_lane_write_mask_n_i(beat.mask_n[0]), .out_clk_held_i(held),
      .rdata_o(rdata), .rvalid_o(rvalid), .rbeat_o(rbeat), .out_clk_sel_o(clk_sel));
   // Narrow organisations share the pins; lane 0 mask doubles as the single mask
   dbw_sram_core #(.ORG(dbw_pkg::DBW_ORG_X18)) u_dut18 (.mclk_i(mclk), .resetn_i(resetn), .rd_sel_n_i(rd_sel_n),
      .wr_sel_n_i(wr_sel_n), .rd_addr_i(rd_addr), .wr_addr_i(wr_addr), .wdata_i(beat.data),
      .byte_write_lane0_n_i(beat.mask_n[0]), .byte_write_lane1_n_i(beat.mask_n[1]),
      .byte_write_lane2_n_i(beat.mask_n[2]), .byte_write_lane3_n_i(beat.mask_n[3]),
      .single_lane_write_mask_n_i(beat.mask_n[0]), .out_clk_held_i(held), .rdata_o(rdata18), .rvalid_o(),
      .rbeat_o(), .out_clk_sel_o());
   dbw_sram_core #(.ORG(dbw_pkg::DBW_ORG_X9)) u_dut9 (.mclk_i(mclk), .resetn_i(resetn), .rd_sel_n_i(rd_sel_n),
      .wr_sel_n_i(wr_sel_n), .rd_addr_i(rd_addr), .wr_addr_i(wr_addr), .wdata_i(beat.data),
      .byte_write_lane0_n_i(beat.mask_n[0]), .byte_write_lane1_n_i(beat.mask_n[1]),
      .byte_write_lane2_n_i(beat.mask_n[2]), .byte_write_lane3_n_i(beat.mask_n[3]),
      .single_lane_write_mask_n_i(beat.mask_n[0]), .out_clk_held_i(held), .rdata_o(rdata9), .rvalid_o(),
      .rbeat_o(), .out_clk_sel_o());
   task automatic close_out();
      $display("compares %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic rd_back(input logic [7:0] a);
      u_ctl.cmd(1'h1, 1'h0, a, 8'h0, 40'h0, 40'h0);
   endtask
   task automatic t_full();
      u_ctl.cmd(1'h0, 1'h1, 8'h0, 8'h1, {36'h123456789, 4'h0}, {36'hfedcba987, 4'h0});
      rd_back(8'h1);
      `CHK("full beat0", 36'h123456789, u_ctl.q0)
      `CHK("full beat1", 36'hfedcba987, u_ctl.q1)
      $display("t_full done");
   endtask
   task automatic t_mask();
      // Different lanes per beat: lane 0 on the first, lane 3 on the second
      u_ctl.cmd(1'h0, 1'h1, 8'h0, 8'h1, {36'h0, 4'he}, {36'h0, 4'h7});
      // Masks low with no write, then a write with every lane masked
      u_ctl.cmd(1'h0, 1'h0, 8'h0, 8'h1, {36'h0, 4'h0}, {36'h0, 4'h0});
      u_ctl.cmd(1'h0, 1'h1, 8'h0, 8'h1, {36'h0, 4'hf}, {36'h0, 4'hf});
      rd_back(8'h1);
      `CHK("mask beat0", 36'h123456600, u_ctl.q0)
      `CHK("mask beat1", 36'h005cba987, u_ctl.q1)
      $display("t_mask done");
   endtask
   task automatic t_conc();
      u_ctl.cmd(1'h1, 1'h1, 8'h1, 8'h2, {36'h555555555, 4'h0}, {36'haaaaaaaaa, 4'h0});
      `CHK("conc beat0", 36'h123456600, u_ctl.q0)
      `CHK("conc beat1", 36'h005cba987, u_ctl.q1)
      u_ctl.cmd(1'h1, 1'h1, 8'h2, 8'h2, {36'h0, 4'hc}, {36'hfffffffff, 4'h0});
      `CHK("fwd beat0", 36'h555540000, u_ctl.q0)
      `CHK("fwd beat1", 36'hfffffffff, u_ctl.q1)
      $display("t_conc done");
   endtask
   task automatic t_org();
      logic [17:0] h0;
      logic [8:0] n0;
      // Clear, then lane 0 only on the first beat and lane 1 only on the second
      u_ctl.cmd(1'h0, 1'h1, 8'h0, 8'h3, 40'h0, 40'h0);
      u_ctl.cmd(1'h0, 1'h1, 8'h0, 8'h3, {36'hfffffffff, 4'he}, {36'hfffffffff, 4'hd});
      fork
         rd_back(8'h3);
         begin
            repeat (4) @(negedge mclk);
            h0 = rdata18[17:0];
            n0 = rdata9[8:0];
         end
      join
      `CHK("x36 lane0", 36'h0000001ff, u_ctl.q0)
      `CHK("x36 lane1", 36'h00003fe00, u_ctl.q1)
      `CHK("x18 beat0", 18'h001ff, h0)
      `CHK("x18 beat1", 18'h3fe00, rdata18[17:0])
      `CHK("x9 beat0", 9'h1ff, n0)
      `CHK("x9 beat1", 9'h000, rdata9[8:0])
      $display("t_org done");
   endtask
   task automatic t_clk();
      @(negedge mclk);
      held = 1'h1;
      repeat (6) @(negedge mclk);
      `CHK("clk held", 1'h1, clk_sel)
      held = 1'h0;
      repeat (6) @(negedge mclk);
      `CHK("clk output", 1'h0, clk_sel)
      $display("t_clk done");
   endtask
   initial
   begin
      #200000;
      failures++;
      close_out();
   end
   initial
   begin
      repeat (5) @(negedge mclk);
      resetn = 1'h1;
      t_full();
      t_mask();
      t_conc();
      t_org();
      t_clk();
      close_out();
   end
endmodule
